/* File: inc/wake_seq_map.vh */
`ifndef WAKE_SEQ_MAP_VH
`define WAKE_SEQ_MAP_VH

// Clock rate in kHz (10 MHz)
`define CLK_KHZ              32'd10000
// Register byte offsets
`define REG_CLK_CFG          8'h00
`define REG_CTRL             8'h04
`define REG_STATUS           8'h08
`define REG_INT_STAT         8'h0C
`define REG_INT_MASK         8'h10
`define REG_WAKE_EN          8'h14
// Clock configuration fields
`define CFG_EXT_OSC_EN       0
`define CFG_LONG_DELAY       1
`define CFG_ADJ_LSB          4
`define CFG_ADJ_MSB          6
`define CFG_RESET            8'h00
// Control fields
`define CTRL_RUN             0
`define CTRL_SUSPEND         3
// Wake enable fields
`define WEN_GPIO             0
`define WEN_TIMER            1
`define WEN_SPI              2
// Interrupt status fields
`define IRQ_TIMER            0
`define IRQ_WOKE             1
`define IRQ_WIDTH            2
// Times as printed (ns / us)
`define T_INT_START_NS       2000
`define T_INT_TMO_US         8
`define T_SHORT_US           128
`define T_LONG_US            4000
`define T_WTMR_BASE_US       1000
// Cycle counts: least times round up
`define CYC_INT_START        ((`T_INT_START_NS * 10 + 999) / 1000)
`define CYC_INT_TMO          (`T_INT_TMO_US * 10)
`define CYC_SHORT            (`T_SHORT_US * 10)
`define CYC_LONG             (`T_LONG_US * 10)
`define CYC_WTMR_BASE        (`T_WTMR_BASE_US * 10)
// Oscillator stability: ticks counted before the clock is trusted
`define OSC_STABLE_CNT       16'd64
// Sequencer states
`define ST_RUN               3'd0
`define ST_SUSP              3'd1
`define ST_INT_START         3'd2
`define ST_INT_TMO           3'd3
`define ST_OSC_WAIT          3'd4
`define ST_EXT_TMO           3'd5

`endif

/* File: logic/wake_timer.v */
`timescale 1ns/1ps
`include "wake_seq_map.vh"

// Periodic wake-up timer; runs only while enabled, count cleared when off
module wake_timer #(
    parameter BASE_CYC = 10000
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Control
    input  wire        enable,
    input  wire [2:0]  adjust,
    // Event
    output reg         tick_q
);
    reg  [31:0] cnt_q;
    wire [31:0] limit;

    // Period grows with adjust: base times (adjust + 1)
    assign limit = BASE_CYC * ({29'd0, adjust} + 32'd1);

    // Disable clears the count so the next enable gives a full period
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= 32'd0;
            tick_q <= 1'b0;
        end else if (!enable) begin
            cnt_q  <= 32'd0;
            tick_q <= 1'b0;
        end else if (cnt_q >= limit - 32'd1) begin
            cnt_q  <= 32'd0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'd1;
            tick_q <= 1'b0;
        end
    end
endmodule

/* File: logic/suspend_wake_clock_sequencer.v */
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "wake_seq_map.vh"

// Summary of operation
// - On wake the clock source follows clock configuration bit 0: internal if 0, external if 1.
// - In internal wake mode the internal oscillator is started within 2 us of the wake event.
// - After the internal clock starts, an 8 us time-out passes before execution is allowed.
// - Setting the external enable while on internal clock stops clocks until the external oscillator is stable, then a 128 us or 4 ms delay.
// - In external wake mode the external oscillator starts on wake, is watched until stable, then the selected delay runs.
// - The wake-up timer runs exactly while its interrupt enable is set, regardless of suspend or global enable.
// - The enabled wake-up timer raises an interrupt at the end of each period, repeating until disabled.
// - Clearing the wake-up interrupt enable resets the count so a later enable yields a full period.
// - Wake-up period is selected by adjust bits in clock configuration, cleared by reset.
// - Suspend is left only on an enabled GPIO, wake-timer or SPI interrupt, or a low D- level.
// - After the wake delays the processor runs the next instruction before any pending interrupt.
module suspend_wake_clock_sequencer (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Wake sources
    input  wire        gpio_irq,
    input  wire        spi_irq,
    input  wire        dminus,
    input  wire        ext_osc_tick,
    // Clock control outputs
    output reg         int_osc_on_q,
    output reg         ext_osc_on_q,
    output reg         cpu_clk_en_q,
    output reg         clk_sel_ext_q,
    output reg         irq_hold_q,
    output reg         irq_q
);
    // Long resume delay and wake timer base in cycles; shorter values speed up runs
    parameter LONG_CYC = `CYC_LONG;
    parameter WTMR_CYC = `CYC_WTMR_BASE;

    // Software-visible registers
    reg  [7:0]  cfg_q;
    reg  [7:0]  ctrl_q;
    reg  [2:0]  wen_q;
    reg  [1:0]  ist_q;
    reg  [1:0]  imask_q;

    // Sequencer state, delay and stability counters
    reg  [2:0]  st_q;
    reg  [31:0] dly_q;
    reg  [15:0] stab_q;
    reg         cfg_ext_prev_q;

    // Write request held until both halves arrive
    reg  [7:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         aw_have_q;
    reg         w_have_q;

    // Wake request, write commit and delay select
    wire        tmr_tick;
    wire        wake;
    wire        do_write;
    wire        ext_sel;
    wire [31:0] ext_cyc;
    reg  [31:0] rd_mux;

    // Wake-up timer; its enable is the timer interrupt enable alone
    wake_timer #(
        .BASE_CYC (WTMR_CYC)
    ) u_wake_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (wen_q[`WEN_TIMER]),
        .adjust  (cfg_q[`CFG_ADJ_MSB:`CFG_ADJ_LSB]),
        .tick_q  (tmr_tick)
    );

    // Only enabled interrupts or a low D- wake the part
    assign wake = (gpio_irq & wen_q[`WEN_GPIO]) | (tmr_tick & wen_q[`WEN_TIMER])
                | (spi_irq & wen_q[`WEN_SPI]) | ~dminus;
    assign ext_sel = cfg_q[`CFG_EXT_OSC_EN];
    assign ext_cyc = cfg_q[`CFG_LONG_DELAY] ? LONG_CYC : `CYC_SHORT;
    assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

    // Write channel: address and data accepted in either order
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end else begin
            // Address phase; awready stays low until the response is taken
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end

            // Data phase
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_have_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end

            // Both halves in: commit and raise the response
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `REG_CLK_CFG, `REG_CTRL, `REG_INT_STAT,
                    `REG_INT_MASK, `REG_WAKE_EN: s_axi_bresp <= 2'b00;
                    default:                     s_axi_bresp <= 2'b10;
                endcase
            end

            // Response taken: reopen both channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register file; hardware sets win over software clears
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q   <= `CFG_RESET;
            ctrl_q  <= 8'h00;
            wen_q   <= 3'b000;
            ist_q   <= 2'b00;
            imask_q <= 2'b00;
        end else begin
            if (do_write && w_strb_q[0]) begin
                case (aw_addr_q)
                    `REG_CLK_CFG:  cfg_q   <= w_data_q[7:0];
                    `REG_CTRL:     ctrl_q  <= w_data_q[7:0];
                    `REG_INT_MASK: imask_q <= w_data_q[1:0];
                    `REG_WAKE_EN:  wen_q   <= w_data_q[2:0];
                    `REG_INT_STAT: ist_q   <= ist_q & ~w_data_q[1:0];
                    default:       ;
                endcase
            end

            // Event sets come after the write so a set beats a clear
            if (tmr_tick) begin
                ist_q[`IRQ_TIMER] <= 1'b1;
            end

            // Resume event on the last cycle of either time-out
            if (st_q != `ST_RUN && st_q != `ST_SUSP && dly_q == 32'd0 && stab_q == 16'd0
                && (st_q == `ST_INT_TMO || st_q == `ST_EXT_TMO)) begin
                ist_q[`IRQ_WOKE] <= 1'b1;
            end

            // Suspend bit self-clears as soon as a wake is taken in suspend
            if (st_q == `ST_SUSP && wake && ctrl_q[`CTRL_RUN]) begin
                ctrl_q[`CTRL_SUSPEND] <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after acceptance
    always @* begin
        case (s_axi_araddr)
            `REG_CLK_CFG:  rd_mux = {24'h000000, cfg_q};
            `REG_CTRL:     rd_mux = {24'h000000, ctrl_q};
            `REG_STATUS:   rd_mux = {24'h000000, cpu_clk_en_q, clk_sel_ext_q,
                                     ext_osc_on_q, int_osc_on_q, 1'b0, st_q};
            `REG_INT_STAT: rd_mux = {30'h00000000, ist_q};
            `REG_INT_MASK: rd_mux = {30'h00000000, imask_q};
            `REG_WAKE_EN:  rd_mux = {29'h00000000, wen_q};
            default:       rd_mux = 32'h00000000;
        endcase
    end

    // Read data registered at acceptance; arready low until the data is taken
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            // Unmapped offsets answer with a slave error and zero data
            case (s_axi_araddr)
                `REG_CLK_CFG, `REG_CTRL, `REG_STATUS, `REG_INT_STAT,
                `REG_INT_MASK, `REG_WAKE_EN: s_axi_rresp <= 2'b00;
                default:                     s_axi_rresp <= 2'b10;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Wake sequencer; the CPU clock is gated in every state but run
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Out of reset the processor runs on the internal oscillator
            st_q           <= `ST_RUN;
            dly_q          <= 32'd0;
            stab_q         <= 16'd0;
            cfg_ext_prev_q <= 1'b0;
            int_osc_on_q   <= 1'b1;
            ext_osc_on_q   <= 1'b0;
            cpu_clk_en_q   <= 1'b1;
            clk_sel_ext_q  <= 1'b0;
            irq_hold_q     <= 1'b0;
        end else begin
            // Edge detector on the external enable; its reset matches the bit's reset
            cfg_ext_prev_q <= ext_sel;
            case (st_q)
                // Running: enter suspend, or gate the clock for a source switch
                `ST_RUN: begin
                    if (ctrl_q[`CTRL_SUSPEND]) begin
                        st_q         <= `ST_SUSP;
                        cpu_clk_en_q <= 1'b0;
                        int_osc_on_q <= 1'b0;
                        ext_osc_on_q <= 1'b0;
                    end else if (ext_sel && !cfg_ext_prev_q && !clk_sel_ext_q) begin
                        st_q         <= `ST_OSC_WAIT;
                        cpu_clk_en_q <= 1'b0;
                        ext_osc_on_q <= 1'b1;
                        stab_q       <= 16'd0;
                    end
                end

                `ST_SUSP: begin
                    // A wake already present still passes through suspend
                    if (wake && ctrl_q[`CTRL_RUN]) begin
                        irq_hold_q <= 1'b1;
                        if (ext_sel) begin
                            st_q         <= `ST_OSC_WAIT;
                            ext_osc_on_q <= 1'b1;
                            stab_q       <= 16'd0;
                        end else begin
                            st_q  <= `ST_INT_START;
                            dly_q <= `CYC_INT_START - 1;
                        end
                    end
                end

                // Internal oscillator restart, well inside the start-up limit
                `ST_INT_START: begin
                    int_osc_on_q <= 1'b1;
                    if (dly_q == 32'd0 || int_osc_on_q) begin
                        st_q  <= `ST_INT_TMO;
                        dly_q <= `CYC_INT_TMO - 1;
                    end else begin
                        dly_q <= dly_q - 32'd1;
                    end
                end

                // Fixed settle time on the internal clock
                `ST_INT_TMO: begin
                    if (dly_q == 32'd0) begin
                        st_q          <= `ST_RUN;
                        clk_sel_ext_q <= 1'b0;
                        cpu_clk_en_q  <= 1'b1;
                    end else begin
                        dly_q <= dly_q - 32'd1;
                    end
                end

                `ST_OSC_WAIT: begin
                    // Stable once enough oscillator ticks have been counted
                    int_osc_on_q <= 1'b0;
                    if (stab_q == `OSC_STABLE_CNT) begin
                        st_q   <= `ST_EXT_TMO;
                        stab_q <= 16'd0;
                        dly_q  <= ext_cyc - 32'd1;
                    end else if (ext_osc_tick) begin
                        stab_q <= stab_q + 16'd1;
                    end
                end

                // Selected delay once the external oscillator is stable
                `ST_EXT_TMO: begin
                    if (dly_q == 32'd0) begin
                        st_q          <= `ST_RUN;
                        clk_sel_ext_q <= 1'b1;
                        cpu_clk_en_q  <= 1'b1;
                    end else begin
                        dly_q <= dly_q - 32'd1;
                    end
                end

                // Unused codes fall back to run
                default: begin
                    st_q <= `ST_RUN;
                end
            endcase

            // Hold interrupts one cycle past resume so the next instruction runs first
            if (st_q == `ST_RUN && cpu_clk_en_q) begin
                irq_hold_q <= 1'b0;
            end
        end
    end

    // Interrupt output
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ist_q & imask_q);
        end
    end
endmodule

/* File: tb/suspend_wake_clock_sequencer_checker.sv */
`timescale 1ns/1ps
module wake_seq_checker #(
    parameter LONG_CYC = 40000
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Wake line and clock control outputs
    input wire dminus,
    input wire int_osc_on_q,
    input wire ext_osc_on_q,
    input wire cpu_clk_en_q,
    input wire clk_sel_ext_q,
    input wire irq_hold_q
);
    // Shortest external path: stability ticks plus the shorter of the two delays
    localparam int EXT_MIN = 64 + ((LONG_CYC < 1280) ? LONG_CYC : 1280);
    wire       asleep = !cpu_clk_en_q && !int_osc_on_q && !ext_osc_on_q;
    reg [15:0] int_cnt_q;
    reg [15:0] ext_cnt_q;
    reg        slept_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Gated cycles per running oscillator; cleared once the processor runs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_cnt_q <= 16'h0000;
            ext_cnt_q <= 16'h0000;
            slept_q   <= 1'b0;
        end else begin
            int_cnt_q <= (cpu_clk_en_q || !int_osc_on_q) ? 16'h0000 : int_cnt_q + 16'h0001;
            ext_cnt_q <= (cpu_clk_en_q || !ext_osc_on_q) ? 16'h0000 : ext_cnt_q + 16'h0001;
            // Marks a resume from suspend; a run-time source switch holds nothing
            slept_q   <= asleep || (slept_q && !cpu_clk_en_q);
        end
    end
    sequence s_line_wake;
        asleep && !dminus;
    endsequence
    sequence s_resume;
        $rose(cpu_clk_en_q);
    endsequence
    property p_wake_start;
        s_line_wake |-> ##[1:20] (int_osc_on_q || ext_osc_on_q);
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("no oscillator after wake");
    property p_int_tmo;
        s_resume ##0 !clk_sel_ext_q |-> (int_cnt_q >= 16'd80) && (int_cnt_q <= 16'd83);
    endproperty
    a_int_tmo: assert property (p_int_tmo) else $error("internal time-out length");
    property p_ext_tmo;
        s_resume ##0 clk_sel_ext_q |-> ext_cnt_q >= EXT_MIN;
    endproperty
    a_ext_tmo: assert property (p_ext_tmo) else $error("external resume too early");
    property p_gate_ext;
        ext_osc_on_q && !clk_sel_ext_q && !cpu_clk_en_q |=> !cpu_clk_en_q || clk_sel_ext_q;
    endproperty
    a_gate_ext: assert property (p_gate_ext) else $error("ran before external stable");
    property p_ext_stop;
        $rose(ext_osc_on_q) && $past(cpu_clk_en_q) |-> !cpu_clk_en_q;
    endproperty
    a_ext_stop: assert property (p_ext_stop) else $error("clock not halted on switch");
    property p_hold_rise;
        s_resume ##0 slept_q |-> irq_hold_q;
    endproperty
    a_hold_rise: assert property (p_hold_rise) else $error("interrupts not held");
    property p_hold_fall;
        $fell(irq_hold_q) |-> $past(cpu_clk_en_q) && cpu_clk_en_q;
    endproperty
    a_hold_fall: assert property (p_hold_fall) else $error("hold released early");
    property p_gate_asleep;
        !int_osc_on_q && !ext_osc_on_q |-> !cpu_clk_en_q;
    endproperty
    a_gate_asleep: assert property (p_gate_asleep) else $error("cpu clock without osc");
endmodule

bind suspend_wake_clock_sequencer wake_seq_checker #(.LONG_CYC(LONG_CYC)) i_chk (
    .clk(clk), .reset_n(reset_n), .dminus(dminus), .int_osc_on_q(int_osc_on_q),
    .ext_osc_on_q(ext_osc_on_q), .cpu_clk_en_q(cpu_clk_en_q),
    .clk_sel_ext_q(clk_sel_ext_q), .irq_hold_q(irq_hold_q)
);

/* File: tb/suspend_wake_clock_sequencer_test.sv */
`timescale 1ns/1ps
`include "wake_seq_map.vh"
module suspend_wake_clock_sequencer_test;
    localparam LONG = 100;
    reg         clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    reg         gpio, spi, dm, tick, arm;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, rv, rnd;
    reg  [1:0]  rs;
    wire        awready, wready, bvalid, arready, rvalid;
    wire        int_on, ext_on, cpu_en, sel_ext, hold, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [2:0]  mon = {irq, cpu_en, !cpu_en};
    integer     err_count, num_checks, seed, cyc, nt, t64, c, s, p, t;
    // Register model: last value written, cut to 3 bits for wake enable, 2 for the mask, 8 for all others
    integer     mdl [0:7];

    // Long counts shortened so the run stays brief
    suspend_wake_clock_sequencer #(.LONG_CYC(LONG), .WTMR_CYC(50)) i_dut (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .gpio_irq(gpio), .spi_irq(spi), .dminus(dm), .ext_osc_tick(tick),
        .int_osc_on_q(int_on), .ext_osc_on_q(ext_on), .cpu_clk_en_q(cpu_en),
        .clk_sel_ext_q(sel_ext), .irq_hold_q(hold), .irq_q(irq)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Random oscillator ticks; the 64th seen during a stability wait is timed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rnd = $random(seed);
        tick <= rnd[0];
        if (arm && tick && ext_on && !cpu_en) begin
            nt = nt + 1;
            if (nt == 64)
                t64 = cyc;
        end
    end

    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task close_out;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // Wait on a monitored flag; a spent bound ends the run
    task wait_on(input integer b, input integer lim);
        begin
            c = 0;
            while (mon[b] !== 1'b1 && c < lim) begin
                @(posedge clk);
                c = c + 1;
            end
            if (c >= lim) begin
                chk("wait", 1, 0);
                close_out;
            end
        end
    endtask

    // One register access; each channel is released at its own handshake
    task bus(input rd, input [7:0] a, input [31:0] d);
        begin
            if (rd) begin
                araddr <= a;
                arvalid <= 1'b1;
                rready <= 1'b1;
            end else begin
                awaddr <= a;
                wdata <= d;
                awvalid <= 1'b1;
                wvalid <= 1'b1;
                bready <= 1'b1;
            end
            c = 0;
            @(posedge clk);
            while (!(rd ? rvalid : bvalid) && c < 50) begin
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
                if (arready)
                    arvalid <= 1'b0;
                @(posedge clk);
                c = c + 1;
            end
            rv = rdata;
            rs = rd ? rresp : bresp;
            bready <= 1'b0;
            rready <= 1'b0;
            if (c >= 50) begin
                chk("bus", 1, 0);
                close_out;
            end
            // Settings that only software changes are held against the model
            if (!rd)
                mdl[a[4:2]] = d & ((a == `REG_WAKE_EN) ? 7 : (a == `REG_INT_MASK) ? 3 : 255);
            else if (a == `REG_CLK_CFG || a == `REG_INT_MASK || a == `REG_WAKE_EN)
                chk("model", mdl[a[4:2]], rv);
            @(posedge clk);
        end
    endtask

    // Gate, stability count, then the delay; resume must be on the external clock
    task ext_wait(input integer d);
        begin
            wait_on(0, 50);
            wait_on(1, 3000);
            chk("ext delay", 1, cyc - t64 >= d && cyc - t64 <= d + 3);
            chk("sel ext", 1, sel_ext);
        end
    endtask

    initial begin
        seed = 32'h8089;
        {awvalid, wvalid, bready, arvalid, rready, gpio, spi, tick, arm} = 9'h000;
        {awaddr, araddr, wdata} = 48'h0;
        dm = 1'b1;
        reset_n = 1'b0;
        {err_count, num_checks, cyc, nt, t64} = 160'h0;
        for (t = 0; t < 8; t = t + 1)
            mdl[t] = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1, `REG_CLK_CFG, 0);
        chk("cfg", 0, rv);
        bus(1, 8'h18, 0);
        chk("slverr", 2, rs);
        bus(0, 8'h18, 0);
        chk("bresp", 2, rs);
        // D-, GPIO and SPI wake sources in turn, the other lines raised but not enabled
        for (s = 0; s < 3; s = s + 1) begin
            bus(0, `REG_WAKE_EN, (s == 1) ? 1 : (s == 2) ? 4 : 0);
            bus(0, `REG_CTRL, 9);
            gpio <= (s != 1);
            spi <= (s != 2);
            repeat (100 + ($random(seed) & 31)) @(posedge clk);
            chk("asleep", 0, cpu_en);
            if (s == 0)
                dm <= 1'b0;
            else if (s == 1)
                gpio <= 1'b1;
            else
                spi <= 1'b1;
            @(posedge clk);
            wait_on(1, 300);
            chk("int wake", 1, c >= 80 && c <= 103);
            chk("sel int", 0, sel_ext);
            bus(1, `REG_CTRL, 0);
            chk("ctrl", 1, rv);
            bus(1, `REG_INT_STAT, 0);
            chk("woke", 2, rv & 2);
            chk("masked", 0, irq);
            bus(0, `REG_INT_STAT, 3);
            {dm, gpio, spi} <= 3'h4;
        end
        // Switch to the external source while running, then wake on it
        arm = 1'b1;
        nt = 0;
        bus(0, `REG_CLK_CFG, 1);
        ext_wait(1280);
        bus(0, `REG_CLK_CFG, 3);
        bus(0, `REG_CTRL, 9);
        repeat (20) @(posedge clk);
        nt = 0;
        dm <= 1'b0;
        ext_wait(LONG);
        dm <= 1'b1;
        arm = 1'b0;
        bus(1, `REG_STATUS, 0);
        chk("status", 32'h000000E0, rv);
        // Wake timer for three adjust values; disabling restarts the count
        bus(0, `REG_INT_MASK, 1);
        bus(1, `REG_INT_MASK, 0);
        for (s = 0; s < 3; s = s + 1) begin
            p = 50 * (s + 1);
            bus(0, `REG_CLK_CFG, 3 | (s << 4));
            bus(1, `REG_CLK_CFG, 0);
            bus(0, `REG_WAKE_EN, 2);
            t = cyc;
            wait_on(2, 1000);
            chk("first", 1, cyc - t >= p - 2 && cyc - t <= p + 3);
            t = cyc;
            bus(0, `REG_INT_STAT, 1);
            repeat (3) @(posedge clk);
            wait_on(2, 1000);
            chk("period", p, cyc - t);
            bus(0, `REG_WAKE_EN, 0);
            bus(0, `REG_INT_STAT, 3);
            repeat (3 * p) @(posedge clk);
            bus(1, `REG_INT_STAT, 0);
            chk("off", 0, rv);
            chk("irq off", 0, irq);
        end
        // Reset in mid-run clears the adjust bits again
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        for (t = 0; t < 8; t = t + 1)
            mdl[t] = 0;
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1, `REG_CLK_CFG, 0);
        chk("cfg", 0, rv);
        close_out;
    end
endmodule
